// >>> pkg/dcr_defs.svh
// Constants of the decoder control, reset and interrupt front end.
// Included by the package only; definitions only.
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH
// Local register addresses
`define DCR_REG_CTRL 8'h01
`define DCR_REG_IRQ_EN 8'h02
`define DCR_REG_EVENT 8'h03
`define DCR_REG_STATUS 8'h1a
// Control register fields
`define DCR_CTRL_SOFT_RST 0
`define DCR_CTRL_HALT 1
`define DCR_CTRL_INMOD_LO 2
`define DCR_CTRL_SYMOD_LO 4
`define DCR_CTRL_RESET 8'h00
`define DCR_IRQ_EN_RESET 5'h00
// Event bit positions
`define DCR_EV_DATA 0
`define DCR_EV_STOP 1
`define DCR_EV_CRC 2
`define DCR_EV_LOCK 3
`define DCR_EV_UNLOCK 4
`define DCR_EV_COUNT 5
// Status register fields
`define DCR_ST_FRAME_TGL 7
`define DCR_ST_DATA 6
`define DCR_ST_LOCKED 1
// Serial addresses
`define DCR_TW_ADDR 6'h18
`define DCR_I2C_ADDR 7'h1d
// Timing
`define DCR_MUTE_FADE_SAMPLES 10'd500
`define DCR_HRST_MIN_FAST 24
`define DCR_HRST_MIN_SLOW 12
`define DCR_I2C_MAX_KBPS 400
`endif

// >>> pkg/dcr_pkg.sv
// Types of the decoder control, reset and interrupt front end.
// Assumes dcr_defs.svh is on the include path.
`include "dcr_defs.svh"
package dcr_pkg;
	typedef struct packed {
		logic [1:0] layer;
		logic [1:0] sfreq;
		logic [3:0] bitrate;
	} dcr_hdr_s;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} dcr_wr_s;
	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_ADDR = 3'b001,
		I_AACK = 3'b010,
		I_WR = 3'b011,
		I_WACK = 3'b100,
		I_RD = 3'b101,
		I_RACK = 3'b110
	} dcr_i2c_e;
endpackage

// >>> core/dcr_top.sv
// Control front end: stop/reset handling, interrupt events, three-wire and I2C slave port.
// Assumes stop and reset pins are asynchronous; the host bit clock is a separate link clock.
// What this block does
// - Stop rising edge aborts decoding, flushes buffer, drops sync, hunts new sync.
// - Soft-mute the output, fading over about 500 samples, while resynchronising.
// - Change of layer, sampling frequency or bit rate acts like a stop edge.
// - Change of input mode or sync mode field acts like a stop edge.
// - Host soft reset command acts like a stop edge.
// - Stop high with halt flag set stops input data requests.
// - Stop high with halt flag clear marks all input data unreliable.
// - Sync and decoding stay suspended while stop is high.
// - Hard reset aborts, soft-mutes and suspends decoding as stop does, and restores default settings.
// - Interrupt events: data available, stop edge, CRC fail, lock set, lock lost.
// - Each source has an enable; only enabled sources drive the interrupt.
// - Hard reset clears all interrupt enables.
// - Reading the event register reports events and clears them.
// - Interrupt output is active low and open drain.
// - Protocol chosen during hard reset, kept until the next hard reset.
// - Port ignores host traffic during hard reset; host sends none.
// - I2C mode: slave with 7-bit address, up to 400 kbit/s.
// - Serial data pin is bidirectional with open-drain driver in both modes.
// - Host drives bit clock and phase select; phase select unused in I2C.
// - Three-wire: 6-bit address in low phase, data in high phase if matched.
// - Two low address bits pick write, read, register address, or status.
`timescale 1ns/1ns
module dcr_top #(
	parameter logic [5:0] TW_ADDR = `DCR_TW_ADDR,
	parameter logic [6:0] I2C_ADDR = `DCR_I2C_ADDR,
	parameter int EV_COUNT = `DCR_EV_COUNT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic stop_pin,
	input wire logic reset_pin,
	input wire logic fast_master_clock_sel,
	input wire logic hdr_valid,
	input wire dcr_pkg::dcr_hdr_s hdr,
	input wire logic crc_fail,
	input wire logic data_items_available,
	input wire logic frame_locked,
	input wire logic frame_toggle,
	input wire logic host_bit_clock,
	input wire logic host_phase_select,
	input wire logic host_serial_data_in,
	output logic host_serial_data_out,
	output logic host_serial_data_oe,
	output logic irq_n_out,
	output logic irq_n_oe,
	output logic decode_abort,
	output logic decode_suspend,
	output logic soft_mute,
	output logic [9:0] mute_fade_len,
	output logic input_request_en,
	output logic corrupt_data_flag,
	output logic halt_input_request_flag,
	output logic [1:0] input_if_mode,
	output logic [1:0] frame_sync_mode,
	output logic three_wire_host_protocol
);
	initial begin
		if (EV_COUNT != 5) begin
			$error("dcr_top serves exactly five interrupt sources");
		end
	end

	// Pin synchronisers on the master clock
	logic stop_m_ff, stop_s_ff, stop_d_ff, rpin_m_ff, rpin_s_ff;
	logic scl_m_ff, scl_s_ff, scl_d_ff, sda_m_ff, sda_s_ff, sda_d_ff, ph_m_ff, ph_s_ff;
	always_ff @(posedge clk) begin
		stop_m_ff <= stop_pin;
		stop_s_ff <= stop_m_ff;
		stop_d_ff <= stop_s_ff;
		rpin_m_ff <= reset_pin;
		rpin_s_ff <= rpin_m_ff;
		scl_m_ff <= host_bit_clock;
		scl_s_ff <= scl_m_ff;
		scl_d_ff <= scl_s_ff;
		sda_m_ff <= host_serial_data_in;
		sda_s_ff <= sda_m_ff;
		sda_d_ff <= sda_s_ff;
		ph_m_ff <= host_phase_select;
		ph_s_ff <= ph_m_ff;
	end
	logic hard;
	logic stop_rise;
	assign hard = rst | rpin_s_ff;
	assign stop_rise = stop_s_ff & ~stop_d_ff;

	// Protocol choice, caught while hard reset is held
	logic mode_i2c_ff;
	always_ff @(posedge clk) begin
		if (hard) begin
			mode_i2c_ff <= ~ph_s_ff;
		end
	end
	assign three_wire_host_protocol = ~mode_i2c_ff;

	// Register writes from either protocol
	logic wr_en;
	dcr_pkg::dcr_wr_s wr;
	logic [7:0] ctrl_ff;
	logic [EV_COUNT-1:0] irq_en_ff, events_ff;
	logic soft_rst_cmd;
	assign soft_rst_cmd = wr_en && wr.addr == `DCR_REG_CTRL && wr.data[`DCR_CTRL_SOFT_RST];
	always_ff @(posedge clk) begin
		if (hard) begin
			ctrl_ff <= `DCR_CTRL_RESET;
		end else if (wr_en && wr.addr == `DCR_REG_CTRL) begin
			ctrl_ff <= {wr.data[7:1], 1'b0};
		end
	end
	always_ff @(posedge clk) begin
		if (hard) begin
			irq_en_ff <= `DCR_IRQ_EN_RESET;
		end else if (wr_en && wr.addr == `DCR_REG_IRQ_EN) begin
			irq_en_ff <= wr.data[EV_COUNT-1:0];
		end
	end
	assign halt_input_request_flag = ctrl_ff[`DCR_CTRL_HALT];
	assign input_if_mode = ctrl_ff[`DCR_CTRL_INMOD_LO+1:`DCR_CTRL_INMOD_LO];
	assign frame_sync_mode = ctrl_ff[`DCR_CTRL_SYMOD_LO+1:`DCR_CTRL_SYMOD_LO];

	// Abort sources
	dcr_pkg::dcr_hdr_s hdr_ff;
	logic hdr_seen_ff;
	logic [3:0] mode_prev_ff;
	logic stream_chg, mode_chg;
	assign stream_chg = hdr_valid && hdr_seen_ff && hdr != hdr_ff;
	assign mode_chg = mode_prev_ff != {frame_sync_mode, input_if_mode};
	always_ff @(posedge clk) begin
		if (hard || decode_abort) begin
			hdr_seen_ff <= 1'b0;
			hdr_ff <= '0;
		end else if (hdr_valid) begin
			hdr_seen_ff <= 1'b1;
			hdr_ff <= hdr;
		end
	end
	always_ff @(posedge clk) begin
		if (hard) begin
			mode_prev_ff <= 4'(`DCR_CTRL_RESET >> `DCR_CTRL_INMOD_LO);
		end else begin
			mode_prev_ff <= {frame_sync_mode, input_if_mode};
		end
	end
	logic abort_ff, mute_ff, lock_d_ff, data_d_ff;
	always_ff @(posedge clk) begin
		abort_ff <= hard | stop_rise | stream_chg | mode_chg | soft_rst_cmd;
	end
	assign decode_abort = abort_ff;
	always_ff @(posedge clk) begin
		if (hard || decode_abort) begin
			mute_ff <= 1'b1;
		end else if (frame_locked && !lock_d_ff && !stop_s_ff) begin
			mute_ff <= 1'b0;
		end
	end
	assign soft_mute = mute_ff;
	assign mute_fade_len = `DCR_MUTE_FADE_SAMPLES;
	assign decode_suspend = stop_s_ff | hard;
	assign input_request_en = ~(stop_s_ff & halt_input_request_flag);
	assign corrupt_data_flag = stop_s_ff & ~halt_input_request_flag;

	// Interrupt events
	logic [EV_COUNT-1:0] ev_new, ev_clr;
	always_ff @(posedge clk) begin
		lock_d_ff <= hard ? 1'b0 : frame_locked;
		data_d_ff <= hard ? 1'b0 : data_items_available;
	end
	always_comb begin
		ev_new = '0;
		ev_new[`DCR_EV_DATA] = data_items_available & ~data_d_ff;
		ev_new[`DCR_EV_STOP] = stop_rise;
		ev_new[`DCR_EV_CRC] = crc_fail;
		ev_new[`DCR_EV_LOCK] = frame_locked & ~lock_d_ff;
		ev_new[`DCR_EV_UNLOCK] = ~frame_locked & lock_d_ff;
	end
	always_ff @(posedge clk) begin
		if (hard) begin
			events_ff <= '0;
		end else begin
			events_ff <= (events_ff & ~ev_clr) | ev_new;
		end
	end
	assign irq_n_out = 1'b0;
	assign irq_n_oe = |(events_ff & irq_en_ff);

	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			`DCR_REG_CTRL: v = ctrl_ff;
			`DCR_REG_IRQ_EN: v = {3'h0, irq_en_ff};
			`DCR_REG_EVENT: v = {3'h0, events_ff};
			`DCR_REG_STATUS: begin
				v[`DCR_ST_FRAME_TGL] = frame_toggle;
				v[`DCR_ST_DATA] = data_items_available;
				v[`DCR_ST_LOCKED] = frame_locked;
			end
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Three-wire engine on the host bit clock
	logic lr_m_ff, lr_s_ff, lm_m_ff, lm_s_ff;
	always_ff @(posedge host_bit_clock) begin
		lr_m_ff <= hard;
		lr_s_ff <= lr_m_ff;
		lm_m_ff <= mode_i2c_ff;
		lm_s_ff <= lm_m_ff;
	end
	logic lrst;
	assign lrst = lr_s_ff | lm_s_ff;
	logic ph_prev_ff, match_ff, req_tgl_ff, req_sts_ff, cons_tgl_ff, wr_tgl_ff;
	logic [2:0] cnt_ff;
	logic [1:0] dom_ff;
	logic [7:0] sh_ff, tw_addr_ff, rdsh_ff;
	dcr_pkg::dcr_wr_s tw_wr_ff;
	logic [7:0] rd_x_ff;
	logic [2:0] nxt_cnt;
	logic [7:0] nxt_sh;
	logic rd_mode;
	assign nxt_cnt = (host_phase_select != ph_prev_ff) ? 3'h0 : cnt_ff;
	assign nxt_sh = {sh_ff[6:0], host_serial_data_in};
	assign rd_mode = match_ff & dom_ff[0];
	always_ff @(posedge host_bit_clock) begin
		if (lrst) begin
			ph_prev_ff <= 1'b0;
			cnt_ff <= 3'h0;
			sh_ff <= 8'h00;
			match_ff <= 1'b0;
			dom_ff <= 2'h0;
			tw_addr_ff <= 8'h00;
			rdsh_ff <= 8'hff;
			req_tgl_ff <= 1'b0;
			req_sts_ff <= 1'b0;
			cons_tgl_ff <= 1'b0;
			wr_tgl_ff <= 1'b0;
			tw_wr_ff <= '0;
		end else begin
			ph_prev_ff <= host_phase_select;
			cnt_ff <= nxt_cnt + 3'h1;
			sh_ff <= nxt_sh;
			rdsh_ff <= {rdsh_ff[6:0], 1'b1};
			if (!host_phase_select) begin
				if (nxt_cnt == 3'h6) begin
					req_sts_ff <= nxt_sh[0]; // Prefetch before the operation bits are complete
					req_tgl_ff <= ~req_tgl_ff;
				end
				if (nxt_cnt == 3'h7) begin
					match_ff <= nxt_sh[7:2] == TW_ADDR;
					dom_ff <= nxt_sh[1:0];
					if (nxt_sh[7:2] == TW_ADDR && nxt_sh[0]) begin
						rdsh_ff <= rd_x_ff;
					end
				end
			end else if (match_ff) begin
				if (rd_mode && nxt_cnt == 3'h6) begin
					req_tgl_ff <= ~req_tgl_ff;
				end
				// Clear only once the host shifts a loaded event byte; status reads never clear
				if (rd_mode && !dom_ff[1] && nxt_cnt == 3'h0 && tw_addr_ff == `DCR_REG_EVENT) begin
					cons_tgl_ff <= ~cons_tgl_ff;
				end
				if (nxt_cnt == 3'h7) begin
					unique case (dom_ff)
						2'b00: begin
							tw_wr_ff <= '{addr: tw_addr_ff, data: nxt_sh};
							wr_tgl_ff <= ~wr_tgl_ff;
						end
						2'b10: tw_addr_ff <= nxt_sh;
						2'b01, 2'b11: begin
							rdsh_ff <= rd_x_ff;
						end
					endcase
				end
			end
		end
	end
	logic tw_drive;
	assign tw_drive = !lrst && host_phase_select && rd_mode && !rdsh_ff[7];

	// Toggle crossings into the master clock domain
	logic [2:0] wt_ff, rt_ff, ct_ff;
	always_ff @(posedge clk) begin
		wt_ff <= {wt_ff[1:0], wr_tgl_ff};
		rt_ff <= {rt_ff[1:0], req_tgl_ff};
		ct_ff <= {ct_ff[1:0], cons_tgl_ff};
	end
	logic tw_wr_ev, tw_req_ev, tw_cons_ev;
	assign tw_wr_ev = wt_ff[2] ^ wt_ff[1];
	assign tw_req_ev = rt_ff[2] ^ rt_ff[1];
	assign tw_cons_ev = ct_ff[2] ^ ct_ff[1];
	logic [EV_COUNT-1:0] tw_snap_ff;
	always_ff @(posedge clk) begin
		if (hard) begin
			rd_x_ff <= 8'hff;
			tw_snap_ff <= '0;
		end else if (tw_req_ev) begin
			rd_x_ff <= reg_read(req_sts_ff ? `DCR_REG_STATUS : tw_addr_ff);
			tw_snap_ff <= events_ff;
		end
	end

	// I2C slave, oversampled on the master clock
	dcr_pkg::dcr_i2c_e ist_ff;
	logic [2:0] ibit_ff;
	logic [7:0] ish_ff, iout_ff, i2c_addr_ff;
	logic ifirst_ff, i2c_oe_ff, i2c_wr_ff, i2c_cons;
	logic [EV_COUNT-1:0] i2c_snap;
	logic scl_rise, scl_fall, i_start, i_stop;
	assign scl_rise = scl_s_ff & ~scl_d_ff;
	assign scl_fall = ~scl_s_ff & scl_d_ff;
	assign i_start = mode_i2c_ff && scl_s_ff && scl_d_ff && !sda_s_ff && sda_d_ff;
	assign i_stop = mode_i2c_ff && scl_s_ff && scl_d_ff && sda_s_ff && !sda_d_ff;
	assign i2c_cons = ist_ff == dcr_pkg::I_AACK && scl_fall && ish_ff[0] && i2c_addr_ff == `DCR_REG_EVENT
		|| ist_ff == dcr_pkg::I_RACK && scl_rise && !sda_s_ff && i2c_addr_ff == `DCR_REG_EVENT;
	assign i2c_snap = i2c_cons ? events_ff : '0;
	logic [7:0] i2c_rd_val;
	always_comb begin
		i2c_rd_val = reg_read(i2c_addr_ff);
	end
	always_ff @(posedge clk) begin
		i2c_wr_ff <= 1'b0;
		if (hard || !mode_i2c_ff || i_stop) begin
			ist_ff <= dcr_pkg::I_IDLE;
			ibit_ff <= 3'h0;
			ish_ff <= 8'h00;
			iout_ff <= 8'hff;
			i2c_addr_ff <= 8'h00;
			ifirst_ff <= 1'b0;
			i2c_oe_ff <= 1'b0;
		end else if (i_start) begin
			ist_ff <= dcr_pkg::I_ADDR;
			ibit_ff <= 3'h0;
			i2c_oe_ff <= 1'b0;
		end else begin
			if (scl_rise && (ist_ff == dcr_pkg::I_ADDR || ist_ff == dcr_pkg::I_WR)) begin
				ish_ff <= {ish_ff[6:0], sda_s_ff};
				ibit_ff <= ibit_ff + 3'h1;
			end
			unique case (ist_ff)
				dcr_pkg::I_IDLE: ;
				dcr_pkg::I_ADDR, dcr_pkg::I_WR: if (scl_fall && ibit_ff == 3'h0 && ish_ff != 8'h00 || scl_fall
					&& ibit_ff == 3'h0 && ist_ff == dcr_pkg::I_WR) begin
					if (ist_ff == dcr_pkg::I_ADDR && ish_ff[7:1] != I2C_ADDR) begin
						ist_ff <= dcr_pkg::I_IDLE;
					end else begin
						i2c_oe_ff <= 1'b1;
						ist_ff <= ist_ff == dcr_pkg::I_ADDR ? dcr_pkg::I_AACK : dcr_pkg::I_WACK;
						if (ist_ff == dcr_pkg::I_ADDR) begin
							ifirst_ff <= 1'b1;
						end else if (ifirst_ff) begin
							i2c_addr_ff <= ish_ff;
							ifirst_ff <= 1'b0;
						end else begin
							i2c_wr_ff <= 1'b1;
						end
					end
				end
				dcr_pkg::I_AACK, dcr_pkg::I_WACK: if (scl_fall) begin
					if (ist_ff == dcr_pkg::I_AACK && ish_ff[0]) begin
						iout_ff <= i2c_rd_val;
						i2c_oe_ff <= !i2c_rd_val[7];
						ist_ff <= dcr_pkg::I_RD;
					end else begin
						i2c_oe_ff <= 1'b0;
						ist_ff <= dcr_pkg::I_WR;
					end
				end
				dcr_pkg::I_RD: if (scl_fall) begin
					ibit_ff <= ibit_ff + 3'h1;
					iout_ff <= {iout_ff[6:0], 1'b1};
					i2c_oe_ff <= ibit_ff != 3'h7 && !iout_ff[6];
					if (ibit_ff == 3'h7) begin
						ist_ff <= dcr_pkg::I_RACK;
					end
				end
				dcr_pkg::I_RACK: if (scl_rise) begin
					if (sda_s_ff) begin
						ist_ff <= dcr_pkg::I_IDLE;
					end else begin
						iout_ff <= i2c_rd_val;
					end
				end else if (scl_fall) begin
					i2c_oe_ff <= !iout_ff[7];
					ist_ff <= dcr_pkg::I_RD;
				end
				default: ist_ff <= dcr_pkg::I_IDLE;
			endcase
		end
	end
	logic [7:0] i2c_wdata_ff;
	always_ff @(posedge clk) begin
		if (scl_fall && ist_ff == dcr_pkg::I_WR) begin
			i2c_wdata_ff <= ish_ff;
		end
	end

	// Merge of both protocols into the register file
	always_comb begin
		wr_en = 1'b0;
		wr = tw_wr_ff;
		ev_clr = '0;
		if (mode_i2c_ff) begin
			wr_en = i2c_wr_ff;
			wr = '{addr: i2c_addr_ff, data: i2c_wdata_ff};
			ev_clr = i2c_snap;
		end else begin
			wr_en = tw_wr_ev;
			ev_clr = tw_cons_ev && tw_snap_ff != '0 ? tw_snap_ff : '0;
		end
	end
	assign host_serial_data_out = 1'b0;
	assign host_serial_data_oe = mode_i2c_ff ? i2c_oe_ff : tw_drive;

	property p_stop_abort;
		@(posedge clk) disable iff (hard) stop_rise |=> decode_abort;
	endproperty
	a_stop_abort: assert property (p_stop_abort) else $error("stop edge without abort");
	property p_mute;
		@(posedge clk) disable iff (hard) decode_abort |=> soft_mute;
	endproperty
	a_mute: assert property (p_mute) else $error("abort without soft mute");
	property p_stream;
		@(posedge clk) disable iff (hard) stream_chg |=> decode_abort;
	endproperty
	a_stream: assert property (p_stream) else $error("stream change without abort");
	property p_halt;
		@(posedge clk) disable iff (hard) stop_s_ff |-> (input_request_en != halt_input_request_flag)
			&& (corrupt_data_flag == !halt_input_request_flag);
	endproperty
	a_halt: assert property (p_halt) else $error("stop level handling wrong");
	property p_suspend;
		@(posedge clk) disable iff (rst) $rose(stop_s_ff) |-> decode_suspend [*3];
	endproperty
	a_suspend: assert property (p_suspend) else $error("suspend dropped under stop");
	property p_en_clear;
		@(posedge clk) $fell(hard) |-> irq_en_ff == '0 && !irq_n_oe;
	endproperty
	a_en_clear: assert property (p_en_clear) else $error("enables not cleared by hard reset");
	property p_irq_gate;
		@(posedge clk) disable iff (hard) irq_n_oe |-> |(events_ff & irq_en_ff) && irq_n_out == 1'b0;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enabled event");
	property p_set_wins;
		@(posedge clk) disable iff (hard) ev_new[`DCR_EV_CRC] |=> events_ff[`DCR_EV_CRC];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost during clear");
	property p_mode_hold;
		@(posedge clk) disable iff (hard) ##1 $stable(mode_i2c_ff);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("protocol changed outside reset");
endmodule

// >>> test/dcr_host_model.sv
// Host microcontroller on the three-wire control port: bit clock, phase select, open-drain data.
// Assumes the bench resolves the data wire with a pull-up and feeds it back on line.
`timescale 1ns/1ns
module dcr_host_model (
	output logic host_bit_clock,
	output logic host_phase_select,
	output logic drive_low,
	input wire logic line
);
	initial begin
		host_bit_clock = 1'b1;
		host_phase_select = 1'b1;
		drive_low = 1'b0;
	end

	// One byte MSB first; each bit moves while the clock is low, the line is taken at the rise, released after the last rise
	task automatic xfer(input logic phase, input logic [7:0] tx, output logic [7:0] rx);
		host_phase_select = phase;
		for (int i = 7; i >= 0; i--) begin
			host_bit_clock = 1'b0;
			drive_low = ~tx[i];
			#62;
			rx[i] = line;
			host_bit_clock = 1'b1;
			#63;
		end
		drive_low = 1'b0;
	endtask

	// Clock edges with the data line released, used around hard reset
	task automatic pulses(input logic strap, input int n);
		host_phase_select = strap;
		repeat (n) begin
			host_bit_clock = 1'b0;
			#62;
			host_bit_clock = 1'b1;
			#63;
		end
	endtask
endmodule

// >>> test/dcr_top_bench.sv
// Self-checking bench of the decoder control front end: stop, hard reset, events, three-wire port.
// Assumes the package, the defines header and the host model are compiled before it.
`timescale 1ns/1ns
module dcr_top_bench;
	logic clk, rst, stop_pin, reset_pin, fast_sel, hdr_valid, crc_fail, dav, locked, tgl;
	dcr_pkg::dcr_hdr_s hdr;
	logic bclk, phase, host_low, sda_oe, sda_out, irq_out, irq_oe, abort, suspend, mute, req_en, corrupt, halt, tw;
	logic [9:0] fade;
	logic [1:0] inmode, symode;
	wire logic sda;
	int fail_count = 0;
	int n_checks = 0;
	int aborts = 0;
	int b, ev_m;
	int unsigned seed = 82838;
	logic [7:0] r, hb;
	logic [4:0] m;
	logic [7:0] q[$] = '{8'h04, 8'h14, 8'h15};
	logic [7:0] flips[4] = '{8'h00, 8'h40, 8'h10, 8'h01};

	assign sda = ~(host_low | sda_oe);

	dcr_top dcr_top_inst (.clk(clk), .rst(rst), .stop_pin(stop_pin), .reset_pin(reset_pin),
		.fast_master_clock_sel(fast_sel), .hdr_valid(hdr_valid), .hdr(hdr), .crc_fail(crc_fail),
		.data_items_available(dav), .frame_locked(locked), .frame_toggle(tgl), .host_bit_clock(bclk),
		.host_phase_select(phase), .host_serial_data_in(sda), .host_serial_data_out(sda_out),
		.host_serial_data_oe(sda_oe), .irq_n_out(irq_out), .irq_n_oe(irq_oe), .decode_abort(abort),
		.decode_suspend(suspend), .soft_mute(mute), .mute_fade_len(fade), .input_request_en(req_en),
		.corrupt_data_flag(corrupt), .halt_input_request_flag(halt), .input_if_mode(inmode),
		.frame_sync_mode(symode), .three_wire_host_protocol(tw));

	dcr_host_model dcr_host_model_inst (.host_bit_clock(bclk), .host_phase_select(phase),
		.drive_low(host_low), .line(sda));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (abort === 1'b1) begin
			aborts <= aborts + 1;
		end
	end

	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
		chk({2'h0, got & mask}, {2'h0, exp & mask});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic tw_op(input logic [1:0] op, input logic [7:0] tx, output logic [7:0] rx);
		logic [7:0] d;
		dcr_host_model_inst.xfer(1'b0, {`DCR_TW_ADDR, op}, d);
		dcr_host_model_inst.xfer(1'b1, tx, rx);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] d;
		tw_op(2'b10, a, d);
		tw_op(2'b00, v, d);
		cyc(30);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		logic [7:0] d;
		tw_op(2'b10, a, d);
		tw_op(2'b01, 8'hff, v);
		cyc(10);
	endtask

	task automatic hard(input logic strap);
		reset_pin = 1'b1;
		dcr_host_model_inst.pulses(strap, 3);
		cyc(30);
		reset_pin = 1'b0;
		cyc(6);
		dcr_host_model_inst.pulses(1'b1, 2);
		cyc(4);
	endtask

	task automatic fire(input int k);
		case (k)
			0: dav = 1'b1;
			1: stop_pin = 1'b1;
			2: crc_fail = 1'b1;
			3: locked = 1'b1;
			default: locked = 1'b0;
		endcase
		cyc(1);
		crc_fail = 1'b0;
		cyc(8);
		stop_pin = 1'b0;
		cyc(8);
	endtask

	task automatic hpulse(input logic [7:0] h);
		hdr = h;
		hdr_valid = 1'b1;
		cyc(1);
		hdr_valid = 1'b0;
		cyc(3);
	endtask

	task automatic end_of_test();
		if (fail_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#500000;
		fail_count++;
		end_of_test();
	end

	initial begin
		{stop_pin, reset_pin, hdr_valid, crc_fail, dav, locked, tgl} = '0;
		fast_sel = 1'b1;
		hdr = '0;
		rst = 1'b1;
		cyc(4);
		rst = 1'b0;
		hard(1'b1);
		chk({tw, irq_oe, irq_out, sda_out, halt}, 5'h10);
		chk({inmode, symode, mute}, 5'h01);
		chk(fade, 10'h1f4);
		// Unmatched address must not reach the enable register
		wr(8'h02, 8'h00);
		dcr_host_model_inst.xfer(1'b0, 8'h64, r);
		dcr_host_model_inst.xfer(1'b1, 8'h1f, r);
		cyc(30);
		b = aborts;
		fire(1);
		chk(10'(aborts - b), 10'h1);
		chk(irq_oe, 1'b0);
		rd(8'h03, r);
		for (int i = 0; i < 2; i++) begin
			m = (i == 0) ? 5'h1f : 5'(xs());
			wr(8'h02, {3'h0, m});
			ev_m = 0;
			for (int k = 0; k < 5; k++) begin
				fire(k);
				ev_m |= 1 << k;
				chk(irq_oe, |(m & 5'(ev_m)));
			end
			rd(8'h03, r);
			chk_byte(r, 8'h1f, {3'h0, m});
			chk(irq_oe, 1'b0);
			dav = 1'b0;
		end
		b = aborts;
		wr(8'h01, 8'h02);
		stop_pin = 1'b1;
		cyc(8);
		chk({req_en, suspend}, 2'h1);
		wr(8'h01, 8'h00);
		chk({req_en, corrupt}, 2'h3);
		stop_pin = 1'b0;
		cyc(8);
		chk({req_en, corrupt, suspend, halt}, 4'h8);
		chk(10'(aborts - b), 10'h1);
		foreach (q[j]) begin
			b = aborts;
			wr(8'h01, q[j]);
			chk(10'(aborts - b), 10'h1);
			chk({inmode, symode, mute}, {q[j][3:2], q[j][5:4], 1'b1});
		end
		rd(8'h01, r);
		chk_byte(r, 8'h14, 8'h3f);
		locked = 1'b1;
		cyc(4);
		chk(mute, 1'b0);
		locked = 1'b0;
		cyc(2);
		hb = 8'(xs());
		for (int f = 0; f < 4; f++) begin
			b = aborts;
			hpulse(hb);
			hpulse(hb ^ flips[f]);
			cyc(10);
			chk(10'(aborts - b), {9'h0, f != 0});
		end
		for (int i = 0; i < 3; i++) begin
			{tgl, dav, locked} = 3'(xs());
			cyc(4);
			tw_op(2'b11, 8'hff, r);
			chk_byte(r, {tgl, dav, 4'h0, locked, 1'b0}, 8'hc2);
			cyc(2);
		end
		wr(8'h01, 8'h16);
		hard(1'b0);
		chk({tw, halt, inmode, symode}, 6'h00);
		wr(8'h01, 8'h02);
		chk(halt, 1'b0);
		hard(1'b1);
		wr(8'h01, 8'h02);
		chk({tw, halt}, 2'h3);
		end_of_test();
	end
endmodule
